// ### scpi_status_reporting.sv
// Top of the status reporting block: command decode, condition inputs,
// two status groups and the error queue.
// Assumes the condition inputs are asynchronous to i_clk and that the
// command port is driven by logic on i_clk, one command per cycle.
`timescale 1ns/10ps
`default_nettype none
module scpi_status_reporting
    import status_pkg::*;
(
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Hardware condition inputs.
    input  wire logic [WORD_W-1:0] i_oper_cond,
    input  wire logic [WORD_W-1:0] i_ques_cond,
    // Error entries from the instrument.
    input  wire logic              i_err_valid,
    input  wire logic [CODE_W-1:0] i_err_code,
    // Command port.
    input  wire logic              i_cmd_valid,
    input  wire cmd_op_e           i_cmd_op,
    input  wire logic [SEL_W-1:0]  i_cmd_sel,
    input  wire logic [CODE_W-1:0] i_cmd_data,
    // Command answer.
    output logic                   o_resp_valid,
    output logic [CODE_W-1:0]      o_resp_data,
    output logic                   o_resp_refused,
    // Status outputs.
    output logic                   o_oper_summary,
    output logic                   o_ques_summary,
    output logic                   o_sweep_reset,
    output logic [QPTR_W:0]        o_err_count
);

    typedef logic [GROUP_CNT-1:0][WORD_W-1:0] word_set_t;

    typedef struct packed {
        word_set_t                               sync1;
        word_set_t                               sync2;
        word_set_t                               sync3;
        word_set_t                               cond;
        logic [QUEUE_DEPTH-1:0][CODE_W-1:0]      queue;
        logic [QPTR_W-1:0]                       head;
        logic [QPTR_W-1:0]                       tail;
        logic [QPTR_W:0]                         count;
        logic                                    resp_valid;
        logic [CODE_W-1:0]                       resp_data;
        logic                                    resp_refused;
        logic                                    sweep_reset;
        logic [GROUP_CNT-1:0]                    summary;
    } top_state_s;

    // True when the select names an existing part.
    function automatic logic sel_ok(input logic [SEL_W-1:0] sel);
        return sel[FIELD_W-1:0] <= FIELD_RISE;
    endfunction : sel_ok

    // True when the select names a part that software may set.
    function automatic logic sel_writable(input logic [SEL_W-1:0] sel);
        return sel_ok(sel) && sel[FIELD_W-1:0] != FIELD_COND &&
               sel[FIELD_W-1:0] != FIELD_EVENT;
    endfunction : sel_writable

    top_state_s state;
    top_state_s next_state;

    word_set_t            cond_in;
    word_set_t            grp_enable;
    word_set_t            grp_latch;
    word_set_t            grp_fall;
    word_set_t            grp_rise;
    logic [GROUP_CNT-1:0] grp_summary;

    logic cmd_read;
    logic cmd_write;
    logic cmd_preset;
    logic cmd_qnext;
    logic cmd_sweep;
    logic cmd_inst;
    logic cmd_known;
    logic write_ok;
    logic read_ok;
    logic push;
    logic pop;
    logic sel_group;

    assign cond_in[GROUP_OPER] = i_oper_cond;
    assign cond_in[GROUP_QUES] = i_ques_cond;

    assign cmd_read   = i_cmd_valid && i_cmd_op == OP_READ;
    assign cmd_write  = i_cmd_valid && i_cmd_op == OP_WRITE;
    assign cmd_preset = i_cmd_valid && i_cmd_op == OP_PRESET;
    assign cmd_qnext  = i_cmd_valid && i_cmd_op == OP_QUEUE_NEXT;
    assign cmd_sweep  = i_cmd_valid && i_cmd_op == OP_SWEEP_RESET;
    assign cmd_inst   = i_cmd_valid && i_cmd_op == OP_INST_RESET;
    assign cmd_known  = cmd_read || cmd_write || cmd_preset ||
                        cmd_qnext || cmd_sweep || cmd_inst;
    assign sel_group  = i_cmd_sel[SEL_GROUP_BIT];

    // Values above fifteen bits are refused whole.
    assign write_ok = cmd_write && sel_writable(i_cmd_sel) &&
                      !i_cmd_data[CODE_W-1];
    assign read_ok  = cmd_read && sel_ok(i_cmd_sel);

    // Zero means no error, so it is never stored.
    assign push = i_err_valid && i_err_code != CODE_NO_ERROR &&
                  (state.count != QUEUE_FULL || pop);
    assign pop  = cmd_qnext && state.count != '0;

    group_if gi [GROUP_CNT] ();

    // Both groups share one structure.
    generate
        for (genvar g = 0; g < GROUP_CNT; g++) begin : g_group
            assign gi[g].cond     = state.cond[g];
            assign gi[g].wr_en    = write_ok &&
                                    sel_group == 1'(g);
            assign gi[g].wr_field = i_cmd_sel[FIELD_W-1:0];
            assign gi[g].wr_data  = i_cmd_data[WORD_W-1:0];
            assign gi[g].rd_clear = read_ok && sel_group == 1'(g) &&
                                    i_cmd_sel[FIELD_W-1:0] == FIELD_EVENT;
            assign gi[g].preset   = cmd_preset;
            assign grp_enable[g]  = gi[g].enable;
            assign grp_latch[g]   = gi[g].latch;
            assign grp_fall[g]    = gi[g].fall;
            assign grp_rise[g]    = gi[g].rise;
            assign grp_summary[g] = gi[g].summary;

            status_group u_group (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .gif     (gi[g])
            );
        end
    endgenerate

    always_comb begin
        logic [WORD_W-1:0] rd_word;
        rd_word = '0;
        next_state = state;

        // Three-stage capture; a change counts once stages two and
        // three agree.
        next_state.sync1 = cond_in;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        next_state.cond  = (state.sync2 & state.sync3) |
                           (state.cond & (state.sync2 | state.sync3));

        next_state.summary = grp_summary;

        case (i_cmd_sel[FIELD_W-1:0])
            FIELD_COND:   rd_word = state.cond[sel_group];
            FIELD_ENABLE: rd_word = grp_enable[sel_group];
            FIELD_EVENT:  rd_word = grp_latch[sel_group];
            FIELD_FALL:   rd_word = grp_fall[sel_group];
            FIELD_RISE:   rd_word = grp_rise[sel_group];
            default:      rd_word = '0;
        endcase

        // Every command gets an answer in the next cycle.
        next_state.resp_valid   = cmd_known;
        next_state.resp_refused = 1'b0;
        next_state.resp_data    = CODE_NO_ERROR;
        next_state.sweep_reset  = cmd_sweep;

        if (read_ok) begin
            next_state.resp_data = {1'b0, rd_word};
        end else if (cmd_qnext) begin
            if (pop) begin
                next_state.resp_data = state.queue[state.head];
            end else begin
                next_state.resp_data = CODE_NO_ERROR;
            end
        end
        if ((cmd_read && !read_ok) || (cmd_write && !write_ok)) begin
            next_state.resp_refused = 1'b1;
        end
        // Instrument reset touches no status part.
        if (cmd_inst) begin
            next_state.resp_data = CODE_NO_ERROR;
        end

        if (push) begin
            next_state.queue[state.tail] = i_err_code;
            next_state.tail = state.tail + 1'b1;
        end
        if (pop) begin
            next_state.head = state.head + 1'b1;
        end
        if (push && !pop) begin
            next_state.count = state.count + 1'b1;
        end else if (pop && !push) begin
            next_state.count = state.count - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_resp_valid   = state.resp_valid;
    assign o_resp_data    = state.resp_data;
    assign o_resp_refused = state.resp_refused;
    assign o_oper_summary = state.summary[GROUP_OPER];
    assign o_ques_summary = state.summary[GROUP_QUES];
    assign o_sweep_reset  = state.sweep_reset;
    assign o_err_count    = state.count;

endmodule : scpi_status_reporting
`default_nettype wire

// ### status_pkg.sv
// Shared constants and types of the status reporting block.
// Assumes nothing beyond a tool that reads packages before modules.
`default_nettype none
package status_pkg;

    localparam int WORD_W      = 15;
    localparam int CODE_W      = 16;
    localparam int GROUP_CNT   = 2;
    localparam int QUEUE_DEPTH = 8;
    localparam int QPTR_W      = 3;
    localparam int SEL_W       = 4;
    localparam int FIELD_W     = 3;

    localparam logic [QPTR_W:0] QUEUE_FULL = (QPTR_W+1)'(QUEUE_DEPTH);

    // Register select: bit 3 picks the group, bits 2:0 the part.
    localparam int            SEL_GROUP_BIT = 3;
    localparam logic [FIELD_W-1:0] FIELD_COND   = 3'h0;
    localparam logic [FIELD_W-1:0] FIELD_ENABLE = 3'h1;
    localparam logic [FIELD_W-1:0] FIELD_EVENT  = 3'h2;
    localparam logic [FIELD_W-1:0] FIELD_FALL   = 3'h3;
    localparam logic [FIELD_W-1:0] FIELD_RISE   = 3'h4;
    localparam int            GROUP_OPER    = 0;
    localparam int            GROUP_QUES    = 1;

    // Preset values and values after reset.
    localparam logic [WORD_W-1:0] RISE_PRESET   = 15'h7fff;
    localparam logic [WORD_W-1:0] FALL_PRESET   = 15'h0000;
    localparam logic [WORD_W-1:0] ENABLE_PRESET = 15'h0000;
    localparam logic [WORD_W-1:0] RISE_RESET    = RISE_PRESET;
    localparam logic [WORD_W-1:0] FALL_RESET    = FALL_PRESET;
    localparam logic [WORD_W-1:0] ENABLE_RESET  = ENABLE_PRESET;
    localparam logic [WORD_W-1:0] LATCH_RESET   = 15'h0000;
    localparam logic [CODE_W-1:0] CODE_NO_ERROR = 16'h0000;

    // Commands, one-hot.
    typedef enum logic [5:0] {
        OP_READ        = 6'h01,
        OP_WRITE       = 6'h02,
        OP_PRESET      = 6'h04,
        OP_QUEUE_NEXT  = 6'h08,
        OP_SWEEP_RESET = 6'h10,
        OP_INST_RESET  = 6'h20
    } cmd_op_e;

endpackage : status_pkg
`default_nettype wire

// ### group_if.sv
// Signals between the top module and one status group.
// Assumes the control side drives all strobes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface group_if;
    import status_pkg::*;

    logic               wr_en;
    logic [FIELD_W-1:0] wr_field;
    logic [WORD_W-1:0]  wr_data;
    logic               rd_clear;
    logic               preset;
    logic [WORD_W-1:0]  cond;
    logic [WORD_W-1:0]  enable;
    logic [WORD_W-1:0]  latch;
    logic [WORD_W-1:0]  fall;
    logic [WORD_W-1:0]  rise;
    logic               summary;

    modport ctrl (
        output wr_en, wr_field, wr_data, rd_clear, preset, cond,
        input  enable, latch, fall, rise, summary
    );
    modport grp (
        input  wr_en, wr_field, wr_data, rd_clear, preset, cond,
        output enable, latch, fall, rise, summary
    );
endinterface : group_if
`default_nettype wire

// ### status_group.sv
// One status group: filters, event latch and enable mask.
// Assumes a condition already synchronised to i_clk.
`timescale 1ns/10ps
`default_nettype none
module status_group
    import status_pkg::*;
(
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Control side.
    group_if.grp      gif
);

    typedef struct packed {
        logic [WORD_W-1:0] enable;
        logic [WORD_W-1:0] latch;
        logic [WORD_W-1:0] fall;
        logic [WORD_W-1:0] rise;
        logic [WORD_W-1:0] cond_prev;
    } group_state_s;

    group_state_s      state;
    group_state_s      next_state;
    logic [WORD_W-1:0] rise_hit;
    logic [WORD_W-1:0] fall_hit;

    assign rise_hit = state.rise & gif.cond & ~state.cond_prev;
    assign fall_hit = state.fall & ~gif.cond & state.cond_prev;

    always_comb begin
        next_state = state;
        next_state.cond_prev = gif.cond;
        if (gif.rd_clear) begin
            next_state.latch = LATCH_RESET;
        end
        // A new event in the clearing cycle survives the clear.
        next_state.latch = next_state.latch | rise_hit | fall_hit;
        if (gif.preset) begin
            next_state.rise   = RISE_PRESET;
            next_state.fall   = FALL_PRESET;
            next_state.enable = ENABLE_PRESET;
        end else if (gif.wr_en) begin
            case (gif.wr_field)
                FIELD_ENABLE: next_state.enable = gif.wr_data;
                FIELD_FALL:   next_state.fall   = gif.wr_data;
                FIELD_RISE:   next_state.rise   = gif.wr_data;
                default:      next_state.enable = state.enable;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '{enable:    ENABLE_RESET,
                       latch:     LATCH_RESET,
                       fall:      FALL_RESET,
                       rise:      RISE_RESET,
                       cond_prev: LATCH_RESET};
        end else begin
            state <= next_state;
        end
    end

    assign gif.enable  = state.enable;
    assign gif.latch   = state.latch;
    assign gif.fall    = state.fall;
    assign gif.rise    = state.rise;
    assign gif.summary = |(state.latch & state.enable);

endmodule : status_group
`default_nettype wire

// ### status_assertions.sv
// Port checker for the status reporting top.
// Assumes it is bound onto scpi_status_reporting and shares its clock.
`timescale 1ns/10ps
`default_nettype none
module status_checker
    import status_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire logic              i_err_valid,
    input wire logic [CODE_W-1:0] i_err_code,
    input wire logic              i_cmd_valid,
    input wire cmd_op_e           i_cmd_op,
    input wire logic [SEL_W-1:0]  i_cmd_sel,
    input wire logic [CODE_W-1:0] i_cmd_data,
    input wire logic              o_resp_valid,
    input wire logic [CODE_W-1:0] o_resp_data,
    input wire logic              o_resp_refused,
    input wire logic              o_oper_summary,
    input wire logic              o_ques_summary,
    input wire logic              o_sweep_reset,
    input wire logic [QPTR_W:0]   o_err_count
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_sweep;
        i_cmd_valid && i_cmd_op == OP_SWEEP_RESET |=> o_sweep_reset;
    endproperty
    a_sweep: assert property (p_sweep) else $error("no sweep pulse");
    property p_inst;
        i_cmd_valid && i_cmd_op == OP_INST_RESET && !i_err_valid |=>
            o_resp_valid && !o_resp_refused && $stable(o_err_count);
    endproperty
    a_inst: assert property (p_inst) else $error("reset changed state");
    property p_wide;
        i_cmd_valid && i_cmd_op == OP_WRITE && i_cmd_data[15] |=>
            o_resp_refused && o_resp_data == 16'h0000;
    endproperty
    a_wide: assert property (p_wide) else $error("wide write taken");
    property p_cond_ro;
        i_cmd_valid && i_cmd_op == OP_WRITE && i_cmd_sel[2:0] == FIELD_COND
            |=> o_resp_valid && o_resp_refused;
    endproperty
    a_cond_ro: assert property (p_cond_ro) else $error("cond written");
    property p_preset;
        i_cmd_valid && i_cmd_op == OP_PRESET |-> ##2
            !o_oper_summary && !o_ques_summary;
    endproperty
    a_preset: assert property (p_preset) else $error("summary on");
    property p_empty;
        i_cmd_valid && i_cmd_op == OP_QUEUE_NEXT && o_err_count == 4'h0 &&
            !i_err_valid |=> o_resp_valid && o_resp_data == 16'h0000;
    endproperty
    a_empty: assert property (p_empty) else $error("empty pop not 0");
    property p_pop;
        i_cmd_valid && i_cmd_op == OP_QUEUE_NEXT && o_err_count != 4'h0 &&
            !i_err_valid |=> o_err_count == $past(o_err_count) - 4'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop count wrong");
    property p_zero;
        i_err_valid && i_err_code == 16'h0000 && !i_cmd_valid |=>
            $stable(o_err_count);
    endproperty
    a_zero: assert property (p_zero) else $error("zero code queued");
endmodule : status_checker
bind scpi_status_reporting status_checker chk (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_err_valid(i_err_valid), .i_err_code(i_err_code),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_sel(i_cmd_sel),
    .i_cmd_data(i_cmd_data), .o_resp_valid(o_resp_valid),
    .o_resp_data(o_resp_data), .o_resp_refused(o_resp_refused),
    .o_oper_summary(o_oper_summary), .o_ques_summary(o_ques_summary),
    .o_sweep_reset(o_sweep_reset), .o_err_count(o_err_count));
`default_nettype wire

// ### host_model.sv
// Remote host that issues one command and takes its answer.
// Assumes the answer is registered on the taking edge and ready 1 ns after it.
`timescale 1ns/10ps
`default_nettype none
module host_model
    import status_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_resp_valid,
    input  wire logic [CODE_W-1:0] i_resp_data,
    input  wire logic              i_resp_refused,
    output logic                   o_cmd_valid,
    output var cmd_op_e            o_cmd_op,
    output logic [SEL_W-1:0]       o_cmd_sel,
    output logic [CODE_W-1:0]      o_cmd_data
);
    logic              refused;
    logic [CODE_W-1:0] rdata;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_op    = OP_READ;
        o_cmd_sel   = 4'h0;
        o_cmd_data  = 16'h0000;
    end
    task automatic cmd(input cmd_op_e op, input logic [SEL_W-1:0] sel,
                       input logic [CODE_W-1:0] data);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_op    <= op;
        o_cmd_sel   <= sel;
        o_cmd_data  <= data;
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_data  <= ~data;
        #1;
        rdata   = (i_resp_valid === 1'b1) ? i_resp_data : 16'hxxxx;
        refused = (i_resp_valid === 1'b1) ? i_resp_refused : 1'bx;
    endtask : cmd
endmodule : host_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the status reporting block.
// Assumes host_model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import status_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n;
    logic [WORD_W-1:0] oper_cond;
    logic [WORD_W-1:0] ques_cond;
    logic              err_valid;
    logic [CODE_W-1:0] err_code;
    logic              cmd_valid;
    cmd_op_e           cmd_op;
    logic [SEL_W-1:0]  cmd_sel;
    logic [CODE_W-1:0] cmd_data;
    logic              resp_valid;
    logic [CODE_W-1:0] resp_data;
    logic              resp_refused;
    logic              oper_sum;
    logic              ques_sum;
    logic              sweep;
    logic [QPTR_W:0]   err_count;
    logic              gb;
    int                fails;
    int                checked;
    scpi_status_reporting DUT (.i_clk(clk), .i_rst_n(rst_n),
        .i_oper_cond(oper_cond), .i_ques_cond(ques_cond),
        .i_err_valid(err_valid), .i_err_code(err_code),
        .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_sel(cmd_sel),
        .i_cmd_data(cmd_data), .o_resp_valid(resp_valid),
        .o_resp_data(resp_data), .o_resp_refused(resp_refused),
        .o_oper_summary(oper_sum), .o_ques_summary(ques_sum),
        .o_sweep_reset(sweep), .o_err_count(err_count));
    host_model host (.i_clk(clk), .i_resp_valid(resp_valid),
        .i_resp_data(resp_data), .i_resp_refused(resp_refused),
        .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op), .o_cmd_sel(cmd_sel),
        .o_cmd_data(cmd_data));
    always #4 clk = ~clk;
    task automatic chk(input string what, input logic [CODE_W-1:0] exp,
                       input logic [CODE_W-1:0] seen);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic rd(input logic [SEL_W-1:0] sel, input logic [15:0] exp);
        host.cmd(OP_READ, sel, 16'h0000);
        chk($sformatf("read %h", sel), exp, host.rdata);
    endtask : rd
    task automatic wr(input logic [SEL_W-1:0] sel, input logic [15:0] d,
                      input logic refuse);
        host.cmd(OP_WRITE, sel, d);
        chk($sformatf("refused %h", sel), {15'h0000, refuse},
            {15'h0000, host.refused});
    endtask : wr
    task automatic setc(input logic [WORD_W-1:0] v);
        @(posedge clk);
        if (gb)
            ques_cond <= v;
        else
            oper_cond <= v;
        repeat (8) @(posedge clk);
        #1;
    endtask : setc
    task automatic push(input logic [CODE_W-1:0] c);
        @(posedge clk);
        err_valid <= 1'b1;
        err_code  <= c;
        @(posedge clk);
        err_valid <= 1'b0;
    endtask : push
    task automatic summarize;
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        rst_n     = 1'b0;
        oper_cond = 15'h0000;
        ques_cond = 15'h0000;
        err_valid = 1'b0;
        err_code  = 16'h0000;
        fails     = 0;
        checked   = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            gb = g[0];
            rd({gb, FIELD_ENABLE}, 16'h0000);
            rd({gb, FIELD_EVENT}, 16'h0000);
            rd({gb, FIELD_FALL}, 16'h0000);
            rd({gb, FIELD_RISE}, 16'h7fff);
            wr({gb, FIELD_ENABLE}, 16'h8000, 1'b1);
            wr({gb, FIELD_COND}, 16'h0001, 1'b1);
            wr({gb, FIELD_FALL}, 16'h0001, 1'b0);
            wr({gb, FIELD_RISE}, 16'h0002, 1'b0);
            wr({gb, FIELD_ENABLE}, 16'h7ffe, 1'b0);
            setc(15'h0003);
            chk("summary on", 16'h0001, {15'h0000, gb ? ques_sum : oper_sum});
            rd({gb, FIELD_EVENT}, 16'h0002);
            rd({gb, FIELD_EVENT}, 16'h0000);
            rd({gb, FIELD_COND}, 16'h0003);
            rd({gb, FIELD_COND}, 16'h0003);
            setc(15'h0000);
            chk("summary off", 16'h0000, {15'h0000, gb ? ques_sum : oper_sum});
            host.cmd(OP_INST_RESET, 4'h0, 16'h0000);
            rd({gb, FIELD_EVENT}, 16'h0001);
            rd({gb, FIELD_ENABLE}, 16'h7ffe);
            host.cmd(OP_PRESET, 4'h0, 16'h0000);
            rd({gb, FIELD_RISE}, 16'h7fff);
            rd({gb, FIELD_FALL}, 16'h0000);
            rd({gb, FIELD_ENABLE}, 16'h0000);
        end
        host.cmd(OP_READ, 4'h5, 16'h0000);
        chk("bad part", 16'h0001, {15'h0000, host.refused});
        host.cmd(OP_SWEEP_RESET, 4'h0, 16'h0000);
        chk("sweep", 16'h0001, {15'h0000, sweep});
        host.cmd(OP_QUEUE_NEXT, 4'h0, 16'h0000);
        chk("queue empty", 16'h0000, host.rdata);
        push(16'hfffb);
        push(16'h0007);
        push(16'h0000);
        @(posedge clk);
        #1;
        chk("count", 16'h0002, {12'h000, err_count});
        host.cmd(OP_QUEUE_NEXT, 4'h0, 16'h0000);
        chk("queue first", 16'hfffb, host.rdata);
        host.cmd(OP_QUEUE_NEXT, 4'h0, 16'h0000);
        chk("queue second", 16'h0007, host.rdata);
        host.cmd(OP_QUEUE_NEXT, 4'h0, 16'h0000);
        chk("queue drained", 16'h0000, host.rdata);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
